// ==== rtl/serial_link_status_and_chan_pd.sv ====
// Contract
// - Status bit 6 shows link up.
// - Status bit 5 returns SYNC~ level.
// - Bit 4 sticky on SYSREF realignment; W1C.
// - Status bit 2 shows PLL lock.
// - Bit 1 powers down B and bound channels.
// - Bit 0 powers down A and bound channels.
// - Both channels down powers down serial subsystem.
// - B disabled keeps link A running.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"

module serial_link_status_and_chan_pd
    import serial_link_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic [`ADDR_W-1:0]       addr,
    input  wire logic [`DATA_W-1:0]       wrData,
    input  wire logic                     wrStrobe,
    input  wire logic                     rdStrobe,
    output logic      [`DATA_W-1:0]       rdData,
    input  wire logic                     linkUpRaw,
    input  wire logic                     syncN,
    input  wire logic                     pllLockedRaw,
    input  wire logic                     serialInterfaceEnable,
    input  wire logic                     sysrefEvent,
    input  wire logic                     sysrefPhaseShift,
    input  wire logic [`DIG_CHANNELS-1:0] boundToB,
    output logic                          irq,
    output logic                          adcPowerDownA,
    output logic                          adcPowerDownB,
    output logic      [`DIG_CHANNELS-1:0] digitalPowerDown,
    output logic                          serialPowerDown
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    sync_if syncBus ();

    assign syncBus.raw[`SYNC_LINK_UP] = linkUpRaw;
    assign syncBus.raw[`SYNC_LEVEL]   = syncN;
    assign syncBus.raw[`SYNC_PLL]     = pllLockedRaw;

    level_sync syncInst (
        .clk    (clk),
        .arst_n (arst_n),
        .port   (syncBus.dst)
    );

    logic linkUp;
    logic syncLevel;
    logic pllLocked;

    assign linkUp    = syncBus.synced[`SYNC_LINK_UP];
    assign syncLevel = syncBus.synced[`SYNC_LEVEL];
    assign pllLocked = syncBus.synced[`SYNC_PLL];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    link_state_t state_r;
    link_state_t state_nxt;

    logic [`DATA_W-1:0] statusView;
    logic [`DATA_W-1:0] powerDownView;
    logic [`DATA_W-1:0] maskView;

    always_comb begin
        statusView                  = '0;
        statusView[`LINK_UP_BIT]    = linkUp;
        statusView[`SYNC_LEVEL_BIT] = syncLevel;
        statusView[`REALIGNED_BIT]  = state_r.realignedFlag;
        statusView[`PHASE_SET_BIT]  = state_r.phaseEstablishedFlag;
        statusView[`PLL_LOCK_BIT]   = pllLocked;

        powerDownView               = '0;
        powerDownView[`PD_B_BIT]    = state_r.powerDownChannelB;
        powerDownView[`PD_A_BIT]    = state_r.powerDownChannelA;

        maskView                    = '0;
        maskView[`REALIGNED_BIT]    = state_r.maskRealigned;
        maskView[`PHASE_SET_BIT]    = state_r.maskPhase;
    end

    logic wrStatus;
    logic wrPowerDown;
    logic wrMask;
    logic enableRise;
    logic realignNext;
    logic phaseNext;

    always_comb begin
        wrStatus    = wrStrobe && (addr == `STATUS_ADDR);
        wrPowerDown = wrStrobe && (addr == `POWER_DOWN_ADDR);
        wrMask      = wrStrobe && (addr == `IRQ_MASK_ADDR);
        enableRise  = serialInterfaceEnable && !state_r.enablePrev;

        state_nxt            = state_r;
        state_nxt.enablePrev = serialInterfaceEnable;

        // Only a written one clears a flag, and a new event in the same cycle wins.
        realignNext = state_r.realignedFlag;
        if (wrStatus && wrData[`REALIGNED_BIT]) begin
            realignNext = 1'b0;
        end
        if (sysrefPhaseShift) begin
            realignNext = 1'b1;
        end

        // Arming on the enable edge means only the first SYSREF after the enable-edge cycle counts; one in that same cycle is ignored.
        if (enableRise) begin
            state_nxt.armed = 1'b1;
        end else if (!serialInterfaceEnable || sysrefEvent) begin
            state_nxt.armed = 1'b0;
        end

        phaseNext = state_r.phaseEstablishedFlag;
        if (wrStatus && wrData[`PHASE_SET_BIT]) begin
            phaseNext = 1'b0;
        end
        if (state_r.armed && serialInterfaceEnable && sysrefEvent) begin
            phaseNext = 1'b1;
        end

        state_nxt.realignedFlag        = realignNext;
        state_nxt.phaseEstablishedFlag = phaseNext;

        // The write is taken whatever the enable; keeping the enable low is the
        // host's duty, since the link cannot retrain mid-frame.
        if (wrPowerDown) begin
            state_nxt.powerDownChannelB = wrData[`PD_B_BIT];
            state_nxt.powerDownChannelA = wrData[`PD_A_BIT];
        end

        if (wrMask) begin
            state_nxt.maskRealigned = wrData[`REALIGNED_BIT];
            state_nxt.maskPhase     = wrData[`PHASE_SET_BIT];
        end

        state_nxt.rdData = '0;
        if (rdStrobe) begin
            unique case (addr)
                `STATUS_ADDR:     state_nxt.rdData = statusView;
                `POWER_DOWN_ADDR: state_nxt.rdData = powerDownView;
                `IRQ_MASK_ADDR:   state_nxt.rdData = maskView;
                default:          state_nxt.rdData = '0;
            endcase
        end

        state_nxt.irq = (realignNext && state_nxt.maskRealigned)
                     || (phaseNext && state_nxt.maskPhase);

        // Power-down outputs follow the register one cycle later.
        state_nxt.adcPdB = state_r.powerDownChannelB;
        state_nxt.adcPdA = state_r.powerDownChannelA;
        for (int i = 0; i < `DIG_CHANNELS; i++) begin
            state_nxt.digitalPd[i] = boundToB[i] ? state_r.powerDownChannelB
                                                 : state_r.powerDownChannelA;
        end
        // Link A stays up with B alone off; only both off stops the subsystem.
        state_nxt.serialPd = state_r.powerDownChannelA
                          && state_r.powerDownChannelB;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r                   <= '0;
            state_r.powerDownChannelA <= `POWER_DOWN_RST;
            state_r.powerDownChannelB <= `POWER_DOWN_RST;
            state_r.maskRealigned     <= `IRQ_MASK_RST;
            state_r.maskPhase         <= `IRQ_MASK_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rdData           = state_r.rdData;
    assign irq              = state_r.irq;
    assign adcPowerDownA    = state_r.adcPdA;
    assign adcPowerDownB    = state_r.adcPdB;
    assign digitalPowerDown = state_r.digitalPd;
    assign serialPowerDown  = state_r.serialPd;

endmodule

`default_nettype wire

// ==== common/serial_link_cfg.svh ====
`ifndef SERIAL_LINK_CFG_SVH
`define SERIAL_LINK_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_W              12
`define DATA_W              8
`define STATUS_ADDR         12'h208
`define POWER_DOWN_ADDR     12'h209
`define IRQ_MASK_ADDR       12'h2f0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LINK_UP_BIT         6
`define SYNC_LEVEL_BIT      5
`define REALIGNED_BIT       4
`define PHASE_SET_BIT       3
`define PLL_LOCK_BIT        2
`define PD_B_BIT            1
`define PD_A_BIT            0

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define POWER_DOWN_RST      1'h0
`define IRQ_MASK_RST        1'h0
`define DIG_CHANNELS        2
`define SYNC_W              3
`define SYNC_LINK_UP        0
`define SYNC_LEVEL          1
`define SYNC_PLL            2

`endif

// ==== common/serial_link_pkg.sv ====
`include "serial_link_cfg.svh"

package serial_link_pkg;

    typedef struct packed {
        logic [`SYNC_W-1:0] stage1;
        logic [`SYNC_W-1:0] stage2;
    } sync_state_t;

    typedef struct packed {
        logic [`DATA_W-1:0]       rdData;
        logic                     powerDownChannelB;
        logic                     powerDownChannelA;
        logic                     maskRealigned;
        logic                     maskPhase;
        logic                     realignedFlag;
        logic                     phaseEstablishedFlag;
        logic                     armed;
        logic                     enablePrev;
        logic                     irq;
        logic                     adcPdA;
        logic                     adcPdB;
        logic [`DIG_CHANNELS-1:0] digitalPd;
        logic                     serialPd;
    } link_state_t;

endpackage

// ==== common/sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"

interface sync_if;
    logic [`SYNC_W-1:0] raw;
    logic [`SYNC_W-1:0] synced;

    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface

`default_nettype wire

// ==== rtl/level_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"

module level_sync
    import serial_link_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    sync_if.dst       port
);

    sync_state_t state_r;
    sync_state_t state_nxt;

    // The first stage feeds only the second one, never any logic.
    always_comb begin
        state_nxt        = state_r;
        state_nxt.stage1 = port.raw;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign port.synced = state_r.stage2;

endmodule

`default_nettype wire

// ==== verif/serial_link_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"

module serial_link_checker
    import serial_link_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     arst_n,
    input wire logic [`ADDR_W-1:0]       addr,
    input wire logic [`DATA_W-1:0]       wrData,
    input wire logic                     wrStrobe,
    input wire logic                     rdStrobe,
    input wire logic [`DATA_W-1:0]       rdData,
    input wire logic                     linkUpRaw,
    input wire logic                     syncN,
    input wire logic                     pllLockedRaw,
    input wire logic                     serialInterfaceEnable,
    input wire logic                     sysrefEvent,
    input wire logic                     sysrefPhaseShift,
    input wire logic [`DIG_CHANNELS-1:0] boundToB,
    input wire logic                     adcPowerDownA,
    input wire logic                     adcPowerDownB,
    input wire logic [`DIG_CHANNELS-1:0] digitalPowerDown,
    input wire logic                     serialPowerDown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic       rdSt;
    logic       rdPd;
    logic       wrSt;
    logic       wrPd;
    logic [1:0] age;
    assign rdSt = rdStrobe && addr == `STATUS_ADDR;
    assign rdPd = rdStrobe && addr == `POWER_DOWN_ADDR;
    assign wrSt = wrStrobe && addr == `STATUS_ADDR;
    assign wrPd = wrStrobe && addr == `POWER_DOWN_ADDR;

    // Mirrored levels are only comparable once the synchroniser holds post-reset values.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end

    status_mirror_a:
    assert property (rdSt && age == 2'h3 |=> rdData[6:5] == {$past(linkUpRaw, 3),
        $past(syncN, 3)} && rdData[2] == $past(pllLockedRaw, 3)) else $error("status mirror");
    status_reserved_a:
    assert property (rdSt |=> rdData[7] == 1'b0 && rdData[1:0] == 2'h0) else $error("status rsv");
    pd_reserved_a:
    assert property (rdPd |=> rdData[7:2] == 6'h00) else $error("pd reserved");
    realign_set_a:
    assert property (sysrefPhaseShift ##1 rdSt |=> rdData[4]) else $error("realign set");
    realign_clear_a:
    assert property (wrSt && wrData[4] && !sysrefPhaseShift ##1 rdSt && !sysrefPhaseShift
        |=> !rdData[4]) else $error("realign clear");
    phase_first_a:
    assert property ($rose(serialInterfaceEnable) ##1 sysrefEvent ##1 rdSt |=> rdData[3])
        else $error("phase flag");
    pd_b_follow_a:
    assert property (wrPd |-> ##2 adcPowerDownB == $past(wrData[1], 2)) else $error("pd b");
    pd_a_follow_a:
    assert property (wrPd |-> ##2 adcPowerDownA == $past(wrData[0], 2)) else $error("pd a");
    digital_bind_a:
    assert property (digitalPowerDown == {$past(boundToB[1]) ? adcPowerDownB : adcPowerDownA,
        $past(boundToB[0]) ? adcPowerDownB : adcPowerDownA}) else $error("digital pd");
    serial_whole_a:
    assert property (serialPowerDown == (adcPowerDownA && adcPowerDownB)) else $error("serial");

    cover property (wrSt ##1 rdSt);
    cover property (wrPd && wrData[1:0] == 2'h3);
    cover property ($rose(serialInterfaceEnable) ##1 sysrefEvent);
endmodule

bind serial_link_status_and_chan_pd serial_link_checker u_serial_link_checker (.*);

`default_nettype wire

// ==== verif/link_receiver_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module link_receiver_model #(
    parameter int HOLD = 20
) (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      syncN
);
    // The receiver keeps SYNC~ asserted until it has code-group sync.
    int count;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 0;
            syncN <= 1'b0;
        end else if (count < HOLD) begin
            count <= count + 1;
        end else begin
            syncN <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_cfg.svh"

module testbench
    import serial_link_pkg::*;
;
    logic       clk = 1'b0, arst_n = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0;
    logic       linkUpRaw = 1'b0, pllLockedRaw = 1'b0, serialInterfaceEnable = 1'b0;
    logic       sysrefEvent = 1'b0, sysrefPhaseShift = 1'b0, syncN, irq;
    logic [11:0] addr = 12'h000;
    logic [7:0] wrData = 8'h00, rdData;
    logic [1:0] boundToB = 2'h0, dig;
    logic       adcA, adcB, serPd;
    int         nMismatch = 0, checkCount = 0;

    always #2 clk = ~clk;

    link_receiver_model u_link_receiver_model (.clk(clk), .arst_n(arst_n), .syncN(syncN));
    serial_link_status_and_chan_pd u_serial_link_status_and_chan_pd (.clk(clk),
        .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .linkUpRaw(linkUpRaw), .syncN(syncN),
        .pllLockedRaw(pllLockedRaw), .serialInterfaceEnable(serialInterfaceEnable),
        .sysrefEvent(sysrefEvent), .sysrefPhaseShift(sysrefPhaseShift), .boundToB(boundToB),
        .irq(irq), .adcPowerDownA(adcA), .adcPowerDownB(adcB), .digitalPowerDown(dig),
        .serialPowerDown(serPd));

    // ------------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Tasks start 1 ns after an edge so strobes may follow back to back.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk(what, exp, rdData);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic endOfTest();
        $display("Checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        linkUpRaw <= 1'b1;
        pllLockedRaw <= 1'b1;
        tick(1);
        rd(`POWER_DOWN_ADDR, 8'h00, "pdReset");
        tick(4);
        rd(`STATUS_ADDR, 8'h44, "statusSyncLow");
        tick(20);
        rd(`STATUS_ADDR, 8'h64, "statusSyncHigh");
        sysrefPhaseShift <= 1'b1;
        tick(1);
        sysrefPhaseShift <= 1'b0;
        rd(`STATUS_ADDR, 8'h74, "realignSet");
        wr(`STATUS_ADDR, 8'hef);
        rd(`STATUS_ADDR, 8'h74, "realignKeep");
        wr(`STATUS_ADDR, 8'h10);
        rd(`STATUS_ADDR, 8'h64, "realignClear");
        wr(`IRQ_MASK_ADDR, 8'h08);
        serialInterfaceEnable <= 1'b1;
        @(posedge clk);
        sysrefEvent <= 1'b1;
        tick(1);
        sysrefEvent <= 1'b0;
        rd(`STATUS_ADDR, 8'h6c, "phaseSet");
        chk("irqOn", 8'h01, {7'h0, irq});
        wr(`IRQ_MASK_ADDR, 8'h00);
        tick(1);
        chk("irqMasked", 8'h00, {7'h0, irq});
        wr(`IRQ_MASK_ADDR, 8'h10);
        sysrefPhaseShift <= 1'b1;
        tick(1);
        sysrefPhaseShift <= 1'b0;
        chk("irqRealign", 8'h01, {7'h0, irq});
        wr(`STATUS_ADDR, 8'h10);
        tick(1);
        chk("irqRealignClear", 8'h00, {7'h0, irq});
        wr(`STATUS_ADDR, 8'h08);
        sysrefEvent <= 1'b1;
        tick(1);
        sysrefEvent <= 1'b0;
        rd(`STATUS_ADDR, 8'h64, "phaseOnce");
        serialInterfaceEnable <= 1'b0;
        wr(12'h2aa, 8'hff);
        rd(12'h2aa, 8'h00, "unmapped");
        for (int v = 0; v < 4; v++) begin
            boundToB <= ~v[1:0];
            wr(`POWER_DOWN_ADDR, 8'hfc | 8'(v));
            tick(2);
            chk("pdOut", {3'h0, v[1] & v[0], v[1], v[0], v[1] & v[0], v[1] | v[0]},
                {3'h0, serPd, adcB, adcA, dig});
            rd(`POWER_DOWN_ADDR, 8'(v), "pdRead");
        end
        endOfTest();
    end

    initial begin
        #20000;
        nMismatch++;
        endOfTest();
    end
endmodule

`default_nettype wire
